// ### design/sstd_defs.svh
// constants for the start/stop trigger character detector
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// - a lone byte equal to the start character starts a read cycle
// - a lone byte equal to the stop character ends the current read cycle in hardware level mode only
// - hardware edge mode acts on start character only, stop is ignored
// - hardware level mode: start character begins, stop character ends the cycle
// - hardware level mode stays in cycle after decode until stop arrives
// - serial-or-hardware edge mode starts on start character or hardware trigger event
// - both characters reset to zero; zero means disabled, never matches
// - start character is 8 bits; host must not pick flow-control on/off characters
// - stop character accepts any 8-bit value, no flow-control exclusion
// - serial-data mode: start character starts a cycle, stop character does nothing
`ifndef SSTD_DEFS_SVH
`define SSTD_DEFS_SVH
`define SSTD_ADDR_START   8'h00
`define SSTD_ADDR_STOP    8'h04
`define SSTD_ADDR_MODE    8'h08
`define SSTD_ADDR_STATUS  8'h0C
`define SSTD_ADDR_CTRL    8'h10
`define SSTD_CHAR_RST     8'h00
`define SSTD_MODE_RST     2'h0
`define SSTD_XON          8'h11
`define SSTD_XOFF         8'h13
`define SSTD_ST_ACTIVE    0
`define SSTD_ST_REJECT    1
`define SSTD_CTRL_DONE    0
`define SSTD_CTRL_ABORT   1
`endif

// ### design/sstd_pkg.sv
// types for the start/stop trigger character detector
package sstd_pkg;
  typedef enum logic [1:0] {
    SSTD_SERIAL   = 2'b00,
    SSTD_HW_EDGE  = 2'b01,
    SSTD_HW_LEVEL = 2'b10,
    SSTD_SER_EDGE = 2'b11
  } sstd_mode_t;
  typedef enum logic [0:0] {
    SSTD_IDLE = 1'b0,
    SSTD_READ = 1'b1
  } sstd_state_t;
endpackage

// ### design/sstd_match.sv
// byte comparator for start and stop trigger characters
`timescale 1ns/1ps
`include "sstd_defs.svh"
module sstd_match #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] rx_byte,     // received byte
  input  wire logic [W-1:0] start_char,  // start character setting
  input  wire logic [W-1:0] stop_char,   // stop character setting
  output logic              hit_start,   // byte matches enabled start
  output logic              hit_stop     // byte matches enabled stop
);
  // a zero setting is disabled so a NUL byte never matches
  assign hit_start = (start_char != '0) && (rx_byte == start_char);
  assign hit_stop  = (stop_char != '0) && (rx_byte == stop_char);
endmodule

// ### design/sstd_top.sv
// start/stop trigger character detector with ahb-lite register slave
`timescale 1ns/1ps
`include "sstd_defs.svh"
module sstd_top (
  input  wire logic               clk,          // 100 MHz clock
  input  wire logic               rst,          // async reset, active high
  input  wire logic               ce,           // clock enable, freezes state when low
  input  wire logic               hsel,         // ahb select
  input  wire logic [7:0]         haddr,        // ahb address
  input  wire logic [1:0]         htrans,       // ahb transfer type
  input  wire logic               hwrite,       // ahb write
  input  wire logic [2:0]         hsize,        // ahb size
  input  wire logic [31:0]        hwdata,       // ahb write data
  input  wire logic               hready,       // ahb bus ready
  output logic [31:0]             hrdata,       // ahb read data
  output logic                    hreadyout,    // ahb slave ready
  output logic                    hresp,        // ahb response, always okay
  input  wire logic [7:0]         rx_byte,      // non-delimited received byte
  input  wire logic               rx_valid,     // one-cycle strobe with rx_byte
  input  wire logic               hw_trig,      // hardware trigger event pulse
  input  wire logic               hw_trig_end,  // hardware level trailing event pulse
  output logic                    read_active,  // read cycle in progress
  output logic                    cycle_start,  // pulse: read cycle started
  output logic                    cycle_end     // pulse: read cycle ended
);
  import sstd_pkg::*;

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [7:0]  start_char;
  logic [7:0]  stop_char;
  sstd_mode_t  mode;
  logic        reject;
  sstd_state_t state;
  logic        hit_start;
  logic        hit_stop;

  //------------------------------------------------------------
  // ahb-lite slave, zero wait states
  //------------------------------------------------------------
  logic       dp_write;
  logic       dp_read;
  logic [7:0] dp_addr;
  logic       ap_take;

  // an address phase is taken only when the bus is ready and the transfer is real
  assign ap_take = hsel && hready && htrans[1];

  // latch the address phase for the following data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (ce && hready) begin
      dp_write <= ap_take && hwrite;
      dp_read  <= ap_take && !hwrite;
      dp_addr  <= haddr;
    end
  end

  // slave is never busy and never errs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data is registered at address phase so it stands through the data phase
  // limitation: a read right behind a write to the same register returns the old value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && ap_take && !hwrite) begin
      unique case (haddr)
        `SSTD_ADDR_START:  hrdata <= {24'h000000, start_char};
        `SSTD_ADDR_STOP:   hrdata <= {24'h000000, stop_char};
        `SSTD_ADDR_MODE:   hrdata <= {30'h0, mode};
        `SSTD_ADDR_STATUS: hrdata <= {30'h0, reject, state == SSTD_READ};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration writes; flow-control values are refused for start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_char <= `SSTD_CHAR_RST;
      stop_char  <= `SSTD_CHAR_RST;
      mode       <= sstd_mode_t'(`SSTD_MODE_RST);
      reject     <= 1'b0;
    end else if (ce && dp_write) begin
      if (dp_addr == `SSTD_ADDR_START) begin
        // keeping the old value avoids a start that swallows flow control
        if (hwdata[7:0] == `SSTD_XON || hwdata[7:0] == `SSTD_XOFF) begin
          reject <= 1'b1;
        end else begin
          start_char <= hwdata[7:0];
          reject     <= 1'b0;
        end
      end
      if (dp_addr == `SSTD_ADDR_STOP) begin
        stop_char <= hwdata[7:0];
      end
      if (dp_addr == `SSTD_ADDR_MODE) begin
        mode <= sstd_mode_t'(hwdata[1:0]);
      end
    end
  end

  //------------------------------------------------------------
  // character compare
  //------------------------------------------------------------
  sstd_match #(.W(8)) u_match (
    .rx_byte    (rx_byte),
    .start_char (start_char),
    .stop_char  (stop_char),
    .hit_start  (hit_start),
    .hit_stop   (hit_stop)
  );

  //------------------------------------------------------------
  // read cycle state
  //------------------------------------------------------------
  logic go;
  logic halt;
  logic sw_done;
  logic sw_abort;

  // control strobes live only in the write data phase, so they act exactly once
  assign sw_done  = dp_write && dp_addr == `SSTD_ADDR_CTRL && hwdata[`SSTD_CTRL_DONE];
  assign sw_abort = dp_write && dp_addr == `SSTD_ADDR_CTRL && hwdata[`SSTD_CTRL_ABORT];

  // start and stop decisions per trigger mode
  always_comb begin
    go   = 1'b0;
    halt = 1'b0;
    unique case (mode)
      SSTD_SERIAL: begin
        go = rx_valid && hit_start;
      end
      SSTD_HW_EDGE: begin
        go = rx_valid && hit_start;
      end
      SSTD_HW_LEVEL: begin
        go   = rx_valid && hit_start;
        halt = (rx_valid && hit_stop) || hw_trig_end;
      end
      SSTD_SER_EDGE: begin
        go = (rx_valid && hit_start) || hw_trig;
      end
    endcase
    // a decode-done does not end a level cycle; only stop, the trailing hardware event or abort does
    if (mode != SSTD_HW_LEVEL && sw_done) begin
      halt = 1'b1;
    end
    if (sw_abort) begin
      halt = 1'b1;
    end
  end

  // read cycle state with registered level and one-cycle start/end pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= SSTD_IDLE;
      read_active <= 1'b0;
      cycle_start <= 1'b0;
      cycle_end   <= 1'b0;
    end else if (ce) begin
      cycle_start <= 1'b0;
      cycle_end   <= 1'b0;
      unique case (state)
        SSTD_IDLE: begin
          // stop while idle is simply dropped
          if (go) begin
            state       <= SSTD_READ;
            read_active <= 1'b1;
            cycle_start <= 1'b1;
          end
        end
        SSTD_READ: begin
          if (halt) begin
            state       <= SSTD_IDLE;
            read_active <= 1'b0;
            cycle_end   <= 1'b1;
          end
        end
      endcase
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  start_char_a: assert property (@(posedge clk) disable iff (rst)
    ce && state == SSTD_IDLE && rx_valid && hit_start |=> read_active && cycle_start)
    else $error("start character did not start a read cycle");

  stop_char_a: assert property (@(posedge clk) disable iff (rst)
    ce && state == SSTD_READ && mode == SSTD_HW_LEVEL && rx_valid && hit_stop |=> !read_active && cycle_end)
    else $error("stop character did not end level read cycle");

  edge_no_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && read_active && mode == SSTD_HW_EDGE && !sw_done && !sw_abort |=> read_active)
    else $error("edge mode read cycle ended without done");

  level_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && read_active && mode == SSTD_HW_LEVEL && !(rx_valid && hit_stop) && !hw_trig_end && !sw_abort
    |=> read_active)
    else $error("level read cycle left without stop");

  hw_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && !read_active && mode == SSTD_SER_EDGE && hw_trig |=> cycle_start)
    else $error("hardware trigger did not start cycle");

  nul_never_a: assert property (@(posedge clk) disable iff (rst)
    start_char == 8'h00 |-> !hit_start)
    else $error("disabled start character matched");

  no_flowctl_a: assert property (@(posedge clk) disable iff (rst)
    start_char != `SSTD_XON && start_char != `SSTD_XOFF)
    else $error("start character holds a flow-control value");

  serial_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && read_active && mode == SSTD_SERIAL && !sw_done && !sw_abort |=> read_active)
    else $error("serial mode cycle ended by stop character");

  idle_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && !read_active && !go |=> !read_active && !cycle_end)
    else $error("idle stop changed state");

  //------------------------------------------------------------
  // further read cycle and register checks
  //------------------------------------------------------------
  // a disabled stop setting must never end a cycle on a NUL byte
  nul_stop_a: assert property (@(posedge clk) disable iff (rst)
    stop_char == 8'h00 |-> !hit_stop)
    else $error("disabled stop character matched");
  // level mode opens on the start character like every other mode
  level_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && !read_active && mode == SSTD_HW_LEVEL && rx_valid && hit_start |=> cycle_start)
    else $error("start character did not open level cycle");
  // the trailing hardware event also closes a level cycle
  level_trail_a: assert property (@(posedge clk) disable iff (rst)
    ce && read_active && mode == SSTD_HW_LEVEL && hw_trig_end |=> !read_active && cycle_end)
    else $error("trailing event did not end level cycle");
  // serial data mode opens on the start character
  serial_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && !read_active && mode == SSTD_SERIAL && rx_valid && hit_start |=> cycle_start)
    else $error("start character did not open serial cycle");
  // hardware edge mode opens on the start character
  edge_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && !read_active && mode == SSTD_HW_EDGE && rx_valid && hit_start |=> cycle_start)
    else $error("start character did not open edge cycle");
  // only the combined mode lets the hardware trigger open a cycle
  hw_mode_only_a: assert property (@(posedge clk) disable iff (rst)
    ce && !read_active && mode != SSTD_SER_EDGE && !(rx_valid && hit_start)
    |=> !read_active)
    else $error("cycle opened without start character");
  // a start arriving during a cycle neither restarts nor ends it
  active_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && read_active && !halt |=> read_active && !cycle_start)
    else $error("active cycle restarted or dropped");
  // abort ends a cycle in every mode
  abort_ends_a: assert property (@(posedge clk) disable iff (rst)
    ce && read_active && sw_abort |=> !read_active && cycle_end)
    else $error("abort did not end the cycle");
  // an accepted start write lands and clears the refusal flag
  start_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && dp_write && dp_addr == `SSTD_ADDR_START && hwdata[7:0] != `SSTD_XON && hwdata[7:0] != `SSTD_XOFF
    |=> start_char == $past(hwdata[7:0]) && !reject)
    else $error("accepted start write did not land");
  // a flow-control start write is refused and flagged
  reject_set_a: assert property (@(posedge clk) disable iff (rst)
    ce && dp_write && dp_addr == `SSTD_ADDR_START && (hwdata[7:0] == `SSTD_XON || hwdata[7:0] == `SSTD_XOFF)
    |=> reject && $stable(start_char))
    else $error("flow-control start write not refused");
  // the stop setting takes any byte
  stop_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && dp_write && dp_addr == `SSTD_ADDR_STOP |=> stop_char == $past(hwdata[7:0]))
    else $error("stop write did not land");
  // a low clock enable holds every piece of state
  freeze_a: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(state) && $stable(start_char) && $stable(stop_char)
    && $stable(mode) && $stable(reject))
    else $error("state moved while clock enable low");
  // a cycle cannot start and end on the same edge
  pulse_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(cycle_start && cycle_end))
    else $error("start and end pulses together");
  // the level output mirrors the state register
  active_state_a: assert property (@(posedge clk) disable iff (rst)
    read_active == (state == SSTD_READ))
    else $error("read_active disagrees with state");
  // a start pulse always comes with an active cycle
  start_pulse_a: assert property (@(posedge clk) disable iff (rst)
    cycle_start |-> read_active)
    else $error("start pulse without active cycle");
  // an end pulse always comes with the cycle closed
  end_pulse_a: assert property (@(posedge clk) disable iff (rst)
    cycle_end |-> !read_active)
    else $error("end pulse with cycle still active");

  //------------------------------------------------------------
  // bus checks
  //------------------------------------------------------------
  // the slave never stalls and never reports an error
  bus_okay_a: assert property (@(posedge clk) disable iff (rst)
    hreadyout && !hresp)
    else $error("slave not ready or not okay");
  // start setting reads back in the data phase that follows
  read_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && ap_take && !hwrite && haddr == `SSTD_ADDR_START
    |=> hrdata == {24'h000000, $past(start_char)})
    else $error("start setting read back wrong");
endmodule

// ### bench/sstd_host_model.sv
// host side model that feeds lone trigger bytes to the detector
`timescale 1ns/1ps
module sstd_host_model (
  input  wire logic       clk,       // device clock
  output logic      [7:0] rx_byte,   // byte to the detector
  output logic            rx_valid   // one-cycle byte strobe
);
  // quiet line shows the inverse of the last byte, so a stale value never matches by luck
  initial begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
  end
  // one lone byte with no delimiters around it
  // callers keep xon/xoff out of the start setting except when a refusal is meant
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_byte  <= ~b;
    rx_valid <= 1'b0;
    #1;
  endtask
endmodule

// ### bench/sstd_top_tb_top.sv
// self-checking bench for the start/stop trigger character detector
`timescale 1ns/1ps
`include "sstd_defs.svh"
module sstd_top_tb_top;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, hw_trig;
  logic        ce, hw_trig_end;
  logic        rx_valid, read_active, cycle_start, cycle_end;
  logic [7:0]  haddr, rx_byte;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  int          n_mismatch, check_count;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  sstd_top dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .hw_trig(hw_trig), .hw_trig_end(hw_trig_end), .read_active(read_active),
    .cycle_start(cycle_start), .cycle_end(cycle_end));
  sstd_host_model host (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid));
  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // one ahb-lite single transfer; waits on ready, the watchdog bounds any hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  // exp packs read_active, cycle_start, cycle_end one edge after the byte
  task automatic lnk(input logic [7:0] b, input logic [2:0] exp, input string what);
    host.send(b);
    chk({29'h0, read_active, cycle_start, cycle_end}, {29'h0, exp}, what);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog: the tests need about 1200 ns, so this limit only trips on a hang
  initial begin
    #50us;
    n_mismatch++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    rst     = 1'b1;
    hsel    = 1'b0;
    haddr   = 8'h00;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0;
    hw_trig = 1'b0;
    hw_trig_end = 1'b0;
    ce      = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // reset values, nul setting never matches
    rdc(`SSTD_ADDR_START, 32'h0, "start reset");
    rdc(`SSTD_ADDR_STOP, 32'h0, "stop reset");
    lnk(8'h00, 3'b000, "nul byte");
    wr(8'h20, 32'hFF);
    rdc(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    // serial data mode: stop does nothing
    wr(`SSTD_ADDR_START, 32'h41);
    wr(`SSTD_ADDR_STOP, 32'h42);
    lnk(8'h42, 3'b000, "stop while idle");
    lnk(8'h41, 3'b110, "serial start");
    lnk(8'h42, 3'b100, "serial stop");
    wr(`SSTD_ADDR_CTRL, 32'h1);
    rdc(`SSTD_ADDR_STATUS, 32'h0, "done ends");
    $display("test serial done");
    // hardware edge mode ignores stop
    wr(`SSTD_ADDR_MODE, 32'h1);
    lnk(8'h41, 3'b110, "edge start");
    lnk(8'h42, 3'b100, "edge stop");
    wr(`SSTD_ADDR_CTRL, 32'h2);
    $display("test edge done");
    // hardware level mode holds the cycle past decode until stop
    wr(`SSTD_ADDR_MODE, 32'h2);
    lnk(8'h42, 3'b000, "level stop idle");
    lnk(8'h41, 3'b110, "level start");
    wr(`SSTD_ADDR_CTRL, 32'h1);
    rdc(`SSTD_ADDR_STATUS, 32'h1, "level after done");
    lnk(8'h42, 3'b001, "level stop");
    $display("test level done");
    // serial-or-hardware edge: either source starts
    wr(`SSTD_ADDR_MODE, 32'h3);
    @(posedge clk);
    hw_trig <= 1'b1;
    @(posedge clk);
    hw_trig <= 1'b0;
    #1;
    chk({29'h0, read_active, cycle_start, cycle_end}, 32'h6, "hw start");
    wr(`SSTD_ADDR_CTRL, 32'h2);
    lnk(8'h41, 3'b110, "char start");
    wr(`SSTD_ADDR_CTRL, 32'h2);
    $display("test either done");
    // flow-control characters: refused for start, fine for stop
    wr(`SSTD_ADDR_START, {24'h000000, `SSTD_XON});
    rdc(`SSTD_ADDR_START, 32'h41, "xon refused");
    rdc(`SSTD_ADDR_STATUS, 32'h2, "reject flag");
    wr(`SSTD_ADDR_STOP, {24'h000000, `SSTD_XOFF});
    rdc(`SSTD_ADDR_STOP, 32'h13, "xoff stop");
    wr(`SSTD_ADDR_MODE, 32'h2);
    lnk(8'h41, 3'b110, "level start");
    lnk(8'h13, 3'b001, "xoff ends");
    wr(`SSTD_ADDR_START, 32'h0);
    rdc(`SSTD_ADDR_STATUS, 32'h0, "reject cleared");
    lnk(8'h00, 3'b000, "disabled start");
    $display("test flow done");
    // level cycle closed by the trailing hardware event, then a frozen clock enable
    wr(`SSTD_ADDR_START, 32'h41);
    lnk(8'h41, 3'b110, "level start again");
    @(posedge clk);
    hw_trig_end <= 1'b1;
    @(posedge clk);
    hw_trig_end <= 1'b0;
    #1;
    chk({29'h0, read_active, cycle_start, cycle_end}, 32'h1, "trailing end");
    @(posedge clk);
    ce <= 1'b0;
    lnk(8'h41, 3'b000, "frozen start");
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk({29'h0, read_active, cycle_start, cycle_end}, 32'h0, "thawed idle");
    $display("test enable done");
    give_verdict();
  end
endmodule
